// ---- core/sccsi_regs.sv ----
// Contact control, status, interrupt flag and enable registers of the card interface.
// Function
// - Card clock pin follows level bit when select is 0, link clock when 1.
// - Clock source switch is synchronised so the card clock never glitches.
// - With UART deselected the I/O pin drives the written I/O bit; reads show pin.
// - I/O, clock level and reset bits change only while supply-in-range reads 1.
// - Clock pin equals clock level bit whenever the synchronised clock select is cleared and supply bit is 1.
// - Reset pin low when reset bit is 0, high when 1.
// - Supply bit 0 powers off the interface and disables other contact bits.
// - Buffer-empty status set on move to shifter, cleared on buffer write, resets 1.
// - Presence status is raw; rising presence with enable raises the interrupt.
// - Supply-in-range status mirrors the supply monitor input.
// - Timeout status sets on expiry, clears only on reload or interface reset.
// - Sent status sets on good transmission only; software clears it.
// - Received status sets on reception, including failed last retry; software clears.
// - Parity status sets on parity error events; software clears it.
// - Buffer-empty flag sets on move to shifter; software clears it.
// - Supply-error flag sets when supply leaves range; software clears it.
// - Timeout flag sets on expiry; software clears it.
// - Sent flag sets on transmission complete; software clears it.
// - Received flag sets on reception complete; software clears it.
// - Parity flag sets with sent or received flag on parity error.
// - Enable register holds one enable per flag; bit 5 reads zero.
// - UART drives I/O pin when UART select is 1.
//
// The plain strobed port was chosen for this implementation.
module sccsi_regs (
  input  wire logic       clk_sys_i,
  input  wire logic       arst_n_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       link_clk_i,
  input  wire logic       io_pin_i,
  output logic            io_pin_o,
  output logic            io_pin_oe_n_o,
  output logic            clk_pin_o,
  output logic            rst_pin_o,
  output logic            supply_on_o,
  input  wire logic       card_present_i,
  input  wire logic       supply_ok_i,
  input  wire logic       uart_io_i,
  input  wire logic       tx_load_i,
  input  wire logic       tx_done_i,
  input  wire logic       rx_done_i,
  input  wire logic       parity_err_i,
  input  wire logic       wt_expire_i,
  input  wire logic       wt_reload_i,
  output logic            buf_write_o,
  output logic            irq_o
);
  logic [7:0] contacts;
  logic [7:0] if_control;
  logic [7:0] irq_enable;
  logic [7:0] irq_flags;
  logic       txbe;
  logic       wto;
  logic [2:0] sw_status;
  logic [1:0] lclk_s;
  logic [1:0] io_s;
  logic [1:0] pres_s;
  logic [1:0] vok_s;
  logic       pres_d;
  logic       vok_d;
  logic       sel_sync;
  logic       lclk;
  logic       io_level_rd;
  logic [7:0] status_rd;
  logic       wr_contacts;
  logic       wr_status;
  logic       wr_flags;

  // Pin inputs pass two flip-flops before use.
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      lclk_s <= 2'h0;
      io_s   <= 2'h3;
      pres_s <= 2'h0;
      vok_s  <= 2'h0;
    end
    else
    begin
      lclk_s <= {lclk_s[0], link_clk_i};
      io_s   <= {io_s[0], io_pin_i};
      pres_s <= {pres_s[0], card_present_i};
      vok_s  <= {vok_s[0], supply_ok_i};
    end
  end

  assign lclk = lclk_s[1];

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pres_d <= 1'b0;
      vok_d  <= 1'b0;
    end
    else
    begin
      pres_d <= pres_s[1];
      vok_d  <= vok_s[1];
    end
  end

  assign wr_contacts = wr_i && (addr_i == sccsi_pkg::ADDR_CONTACTS);
  assign wr_status   = wr_i && (addr_i == sccsi_pkg::ADDR_STATUS);
  assign wr_flags    = wr_i && (addr_i == sccsi_pkg::ADDR_IRQ_FLAGS);
  assign buf_write_o = wr_i && (addr_i == sccsi_pkg::ADDR_CHAR_BUF);

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      contacts <= sccsi_pkg::RST_CONTACTS;
    end
    else if (wr_contacts)
    begin
      contacts[sccsi_pkg::BIT_CLK_SEL]   <= wdata_i[sccsi_pkg::BIT_CLK_SEL];
      contacts[sccsi_pkg::BIT_SUPPLY_ON] <= wdata_i[sccsi_pkg::BIT_SUPPLY_ON];
      if (vok_s[1])
      begin
        contacts[sccsi_pkg::BIT_IO_LEVEL]  <= wdata_i[sccsi_pkg::BIT_IO_LEVEL];
        contacts[sccsi_pkg::BIT_CLK_LEVEL] <= wdata_i[sccsi_pkg::BIT_CLK_LEVEL];
        contacts[sccsi_pkg::BIT_RST_LEVEL] <= wdata_i[sccsi_pkg::BIT_RST_LEVEL];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      if_control <= sccsi_pkg::RST_IF_CONTROL;
    end
    else if (wr_i && (addr_i == sccsi_pkg::ADDR_IF_CONTROL))
    begin
      if_control <= wdata_i;
    end
  end

  // Enable register, reserved bit held at zero.
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      irq_enable <= sccsi_pkg::RST_IRQ_ENABLE;
    end
    else if (wr_i && (addr_i == sccsi_pkg::ADDR_IRQ_ENABLE))
    begin
      irq_enable <= wdata_i & sccsi_pkg::MASK_ENABLE;
    end
  end

  // Source switches only while the link clock is low, so no runt pulse.
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sel_sync     <= 1'b0;
    end
    else if (!lclk && !contacts[sccsi_pkg::BIT_CLK_LEVEL])
    begin
      sel_sync <= contacts[sccsi_pkg::BIT_CLK_SEL];
    end
  end

  // Card clock source mux, registered for a clean edge.
  // Level bit drives the pin while select is cleared.
  // Without supply all contacts are held low.
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      clk_pin_o <= 1'b0;
      rst_pin_o <= 1'b0;
      io_pin_o  <= 1'b0;
      io_pin_oe_n_o <= 1'b1;
    end
    else if (!contacts[sccsi_pkg::BIT_SUPPLY_ON])
    begin
      clk_pin_o <= 1'b0;
      rst_pin_o <= 1'b0;
      io_pin_o  <= 1'b0;
      io_pin_oe_n_o <= 1'b0;
    end
    else
    begin
      clk_pin_o <= sel_sync ? lclk : contacts[sccsi_pkg::BIT_CLK_LEVEL];
      rst_pin_o <= contacts[sccsi_pkg::BIT_RST_LEVEL];
      // Open-drain: drive low for 0, release for 1 so the pin can be read.
      if (if_control[sccsi_pkg::BIT_UART_SEL])
      begin
        io_pin_o      <= 1'b0;
        io_pin_oe_n_o <= uart_io_i;
      end
      else
      begin
        io_pin_o      <= 1'b0;
        io_pin_oe_n_o <= contacts[sccsi_pkg::BIT_IO_LEVEL];
      end
    end
  end

  assign io_level_rd = contacts[sccsi_pkg::BIT_IO_LEVEL] & io_s[1];

  // Buffer empty: set on load into shifter wins over a buffer write.
  // Timeout status set on expiry, cleared by reload.
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      txbe <= sccsi_pkg::RST_STATUS[sccsi_pkg::BIT_TXBE];
      wto  <= 1'b0;
    end
    else
    begin
      if (tx_load_i)
        txbe <= 1'b1;
      else if (buf_write_o)
        txbe <= 1'b0;
      if (wt_expire_i)
        wto <= 1'b1;
      else if (wt_reload_i)
        wto <= 1'b0;
    end
  end

  // Character status bits, hardware set wins over clear.
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sw_status <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (wr_status && !wdata_i[i])
          sw_status[i] <= 1'b0;
      end
      if (tx_done_i && !parity_err_i)
        sw_status[sccsi_pkg::BIT_SENT] <= 1'b1;
      if (rx_done_i)
        sw_status[sccsi_pkg::BIT_RECV] <= 1'b1;
      if (parity_err_i && (tx_done_i || rx_done_i))
        sw_status[sccsi_pkg::BIT_PERR] <= 1'b1;
    end
  end

  // Sticky flags; writing 0 clears, set wins.
  // Presence rising edge latches the card-in flag bit.
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      irq_flags <= sccsi_pkg::RST_IRQ_FLAGS;
    end
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (wr_flags && !wdata_i[i])
          irq_flags[i] <= 1'b0;
      end
      if (tx_load_i)
        irq_flags[sccsi_pkg::BIT_TXBE] <= 1'b1;
      if (pres_s[1] && !pres_d)
        irq_flags[sccsi_pkg::BIT_CARD] <= 1'b1;
      if (vok_d && !vok_s[1])
        irq_flags[sccsi_pkg::BIT_VOK] <= 1'b1;
      if (wt_expire_i)
        irq_flags[sccsi_pkg::BIT_WTO] <= 1'b1;
      if (tx_done_i)
        irq_flags[sccsi_pkg::BIT_SENT] <= 1'b1;
      if (rx_done_i)
        irq_flags[sccsi_pkg::BIT_RECV] <= 1'b1;
      if (parity_err_i && (tx_done_i || rx_done_i))
        irq_flags[sccsi_pkg::BIT_PERR] <= 1'b1;
    end
  end

  // Single interrupt from flag and enable pairs.
  assign irq_o = |(irq_flags & irq_enable);

  assign status_rd = {txbe, pres_s[1], 1'b0, vok_s[1], wto, sw_status};

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_o <= 8'h00;
    end
    else if (rd_i)
    begin
      case (addr_i)
        sccsi_pkg::ADDR_IRQ_ENABLE: rdata_o <= irq_enable;
        sccsi_pkg::ADDR_IRQ_FLAGS:  rdata_o <= irq_flags & sccsi_pkg::MASK_FLAGS
                                               | (irq_flags & 8'h40);
        sccsi_pkg::ADDR_STATUS:     rdata_o <= status_rd;
        sccsi_pkg::ADDR_CONTACTS:   rdata_o <= {contacts[7:4], io_level_rd, contacts[2:0]}
                                               & sccsi_pkg::MASK_CONTACTS;
        sccsi_pkg::ADDR_IF_CONTROL: rdata_o <= if_control;
        default:                    rdata_o <= 8'h00;
      endcase
    end
    else
    begin
      rdata_o <= 8'h00;
    end
  end

  // Enabled buffer-empty event raises the interrupt.
  irq_pair_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    tx_load_i && irq_enable[sccsi_pkg::BIT_TXBE]
      && !(wr_i && (addr_i == sccsi_pkg::ADDR_IRQ_ENABLE)) |=> irq_o)
    else $error("irq not raised");
  txbe_set_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    tx_load_i |=> txbe) else $error("txbe not set");
  txbe_clr_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    buf_write_o && !tx_load_i |=> !txbe) else $error("txbe not cleared");
  wto_hold_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    wto && !wt_reload_i |=> wto) else $error("timeout lost");
  wto_flag_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    wt_expire_i |=> irq_flags[3]) else $error("timeout flag missing");
  // Failed send never sets sent status.
  sent_good_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    $rose(sw_status[2]) |-> $past(tx_done_i) && !$past(parity_err_i))
    else $error("sent status wrongly set");
  // Reset pin follows bit when powered.
  rst_pin_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    contacts[0] |=> rst_pin_o == $past(contacts[1])) else $error("reset pin wrong");
  supply_off_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !contacts[0] |=> !clk_pin_o && !rst_pin_o) else $error("contacts active unpowered");
  en_rsvd_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !irq_enable[5]) else $error("reserved enable set");
  // Level bits frozen without supply in range.
  lvl_gate_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !vok_s[1] |=> $stable(contacts[3:1])) else $error("level changed unpowered");
  // Clock source switches only while the pin is low.
  clk_switch_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    $changed(sel_sync) |-> !clk_pin_o) else $error("clock source switched while high");
  // Software I/O bit drives the pin while the UART is deselected.
  io_bit_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    contacts[0] && !if_control[3] |=> io_pin_oe_n_o == $past(contacts[3]))
    else $error("io pin does not follow io bit");
  // UART level drives the pin while the UART is selected.
  uart_io_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    contacts[0] && if_control[3] |=> io_pin_oe_n_o == $past(uart_io_i))
    else $error("io pin does not follow uart");
  // Presence rising edge sets the card-in flag.
  pres_flag_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    pres_s[1] && !pres_d |=> irq_flags[6]) else $error("presence flag missing");
  // Supply leaving range sets the supply-error flag.
  vok_flag_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    vok_d && !vok_s[1] |=> irq_flags[4]) else $error("supply flag missing");

  assign supply_on_o = contacts[sccsi_pkg::BIT_SUPPLY_ON];
endmodule

// ---- pkg/sccsi_pkg.sv ----
// Package with register map, field positions and reset values of the card contact block.
package sccsi_pkg;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hFB;
  localparam logic [7:0] ADDR_IRQ_FLAGS  = 8'hFC;
  localparam logic [7:0] ADDR_STATUS     = 8'hFD;
  localparam logic [7:0] ADDR_CONTACTS   = 8'hFE;
  localparam logic [7:0] ADDR_IF_CONTROL = 8'hFF;
  localparam logic [7:0] ADDR_CHAR_BUF   = 8'hF9;

  localparam int BIT_CLK_SEL   = 7;
  localparam int BIT_IO_LEVEL  = 3;
  localparam int BIT_CLK_LEVEL = 2;
  localparam int BIT_RST_LEVEL = 1;
  localparam int BIT_SUPPLY_ON = 0;

  localparam int BIT_TXBE  = 7;
  localparam int BIT_CARD  = 6;
  localparam int BIT_RSVD  = 5;
  localparam int BIT_VOK   = 4;
  localparam int BIT_WTO   = 3;
  localparam int BIT_SENT  = 2;
  localparam int BIT_RECV  = 1;
  localparam int BIT_PERR  = 0;

  localparam int BIT_UART_SEL = 3;

  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] RST_IRQ_FLAGS  = 8'h00;
  localparam logic [7:0] RST_STATUS     = 8'h80;
  localparam logic [7:0] RST_CONTACTS   = 8'h00;
  localparam logic [7:0] RST_IF_CONTROL = 8'h00;
  localparam logic [7:0] MASK_CONTACTS  = 8'h8F;
  localparam logic [7:0] MASK_ENABLE    = 8'hDF;
  localparam logic [7:0] MASK_FLAGS     = 8'h9F;
  localparam logic [7:0] MASK_STATUS_SW = 8'h07;
endpackage

// ---- verification/sccsi_card_model.sv ----
// Behavioural smart card sitting on the contacts of the card interface.
module sccsi_card_model (
  input  wire logic supply_on_i,
  input  wire logic rst_pin_i,
  input  wire logic io_oe_n_i,
  input  wire logic pull_low_i,
  input  wire logic inserted_i,
  output logic      io_line_o,
  output logic      present_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic card_pulls;

  // card acts only powered.
  // The card pulls the line only while it is powered and out of reset.
  assign card_pulls = pull_low_i & supply_on_i & rst_pin_i;
  // The I/O line has a pull-up, so a released line reads high.
  assign io_line_o  = ~(~io_oe_n_i | card_pulls);
  assign present_o  = inserted_i;
endmodule

// ---- verification/sccsi_regs_test.sv ----
// Register-level testbench of the card contact, status and interrupt block.
module sccsi_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk_sys_i;
  logic       arst_n_i;
  logic       link_clk;
  logic       wr;
  logic       rd;
  logic       supply_ok;
  logic       inserted;
  logic       pull_low;
  logic       prev;
  logic       buf_seen;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [5:0] ev;
  logic       io_line;
  logic       io_oe_n;
  logic       io_pin;
  logic       uart_io;
  logic       clk_pin;
  logic       rst_pin;
  logic       supply_on;
  logic       present;
  logic       buf_wr;
  logic       irq;
  int         bad_count;
  int         checked;
  int         cyc;
  int         tog;
  logic [5:0] ev_tab   [5] = '{6'h02, 6'h04, 6'h0C, 6'h01, 6'h0A};
  logic [7:0] flag_tab [5] = '{8'h04, 8'h02, 8'h03, 8'h80, 8'h05};
  logic [7:0] stat_tab [5] = '{8'h94, 8'h92, 8'h93, 8'h90, 8'h91};

  sccsi_regs dut (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .link_clk_i(link_clk), .io_pin_i(io_line),
    .io_pin_o(io_pin), .io_pin_oe_n_o(io_oe_n), .clk_pin_o(clk_pin), .rst_pin_o(rst_pin),
    .supply_on_o(supply_on), .card_present_i(present), .supply_ok_i(supply_ok),
    .uart_io_i(uart_io), .tx_load_i(ev[0]), .tx_done_i(ev[1]), .rx_done_i(ev[2]),
    .parity_err_i(ev[3]), .wt_expire_i(ev[4]), .wt_reload_i(ev[5]),
    .buf_write_o(buf_wr), .irq_o(irq)
  );

  sccsi_card_model card (
    .supply_on_i(supply_on), .rst_pin_i(rst_pin), .io_oe_n_i(io_oe_n),
    .pull_low_i(pull_low), .inserted_i(inserted), .io_line_o(io_line), .present_o(present)
  );

  initial
  begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  initial
  begin
    link_clk = 1'b0;
    forever #24 link_clk = ~link_clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Bounds the run well above the expected few hundred cycles.
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (buf_wr === 1'b1)
      buf_seen <= 1'b1;
    if (cyc == 20000)
    begin
      bad_count = bad_count + 1;
      wrap_up();
    end
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk_sys_i);
    wr    <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys_i);
    rd   <= 1'b0;
    #1 chk(name, rdata, exp);
  endtask

  task automatic pulse(input logic [5:0] v);
    @(posedge clk_sys_i);
    ev <= v;
    @(posedge clk_sys_i);
    ev <= 6'h00;
  endtask

  initial
  begin
    arst_n_i = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00; ev = 6'h00;
    supply_ok = 1'b0; inserted = 1'b0; pull_low = 1'b0; buf_seen = 1'b0;
    bad_count = 0; checked = 0; cyc = 0; uart_io = 1'b1;
    idle(20);
    arst_n_i <= 1'b1;
    rchk("enable reset", sccsi_pkg::ADDR_IRQ_ENABLE, 8'h00);
    rchk("flags reset", sccsi_pkg::ADDR_IRQ_FLAGS, 8'h00);
    rchk("status reset", sccsi_pkg::ADDR_STATUS, 8'h80);
    rchk("contacts reset", sccsi_pkg::ADDR_CONTACTS, 8'h00);
    rchk("unmapped read", 8'hF0, 8'h00);
    wr_reg(sccsi_pkg::ADDR_IRQ_ENABLE, 8'hFF);
    rchk("enable mask", sccsi_pkg::ADDR_IRQ_ENABLE, 8'hDF);
    $display("test registers done");
    wr_reg(sccsi_pkg::ADDR_CONTACTS, 8'h0F);
    idle(3);
    chk("rst gated", {7'h00, rst_pin}, 8'h00);
    chk("clk gated", {7'h00, clk_pin}, 8'h00);
    chk("supply on", {7'h00, supply_on}, 8'h01);
    supply_ok <= 1'b1;
    idle(4);
    wr_reg(sccsi_pkg::ADDR_CONTACTS, 8'h0F);
    idle(3);
    chk("rst high", {7'h00, rst_pin}, 8'h01);
    chk("clk level", {7'h00, clk_pin}, 8'h01);
    chk("io released", {7'h00, io_oe_n}, 8'h01);
    rchk("status ok", sccsi_pkg::ADDR_STATUS, 8'h90);
    pull_low <= 1'b1;
    idle(4);
    rchk("io read pin", sccsi_pkg::ADDR_CONTACTS, 8'h07);
    pull_low <= 1'b0;
    wr_reg(sccsi_pkg::ADDR_CONTACTS, 8'h05);
    idle(3);
    chk("io driven", {7'h00, io_oe_n}, 8'h00);
    chk("rst low", {7'h00, rst_pin}, 8'h00);
    chk("io pin low", {7'h00, io_pin}, 8'h00);
    wr_reg(sccsi_pkg::ADDR_IF_CONTROL, 8'h08);
    idle(3);
    chk("uart releases io", {7'h00, io_oe_n}, 8'h01);
    uart_io <= 1'b0;
    idle(3);
    chk("uart drives io", {7'h00, io_oe_n}, 8'h00);
    rchk("control read", sccsi_pkg::ADDR_IF_CONTROL, 8'h08);
    wr_reg(sccsi_pkg::ADDR_IF_CONTROL, 8'h00);
    uart_io <= 1'b1;
    idle(3);
    chk("io bit again", {7'h00, io_oe_n}, 8'h00);
    wr_reg(sccsi_pkg::ADDR_CONTACTS, 8'h89);
    idle(30);
    tog = 0;
    repeat (80)
    begin
      prev = clk_pin;
      @(posedge clk_sys_i);
      #1 if (clk_pin !== prev) tog = tog + 1;
    end
    chk("clk follows link", {7'h00, tog > 4}, 8'h01);
    wr_reg(sccsi_pkg::ADDR_CONTACTS, 8'h09);
    idle(40);
    chk("clk level low", {7'h00, clk_pin}, 8'h00);
    wr_reg(sccsi_pkg::ADDR_CONTACTS, 8'h0E);
    idle(3);
    chk("supply off", {7'h00, supply_on}, 8'h00);
    $display("test contacts done");
    for (int i = 0; i < 5; i++)
    begin
      if (i == 3)
      begin
        wr_reg(sccsi_pkg::ADDR_CHAR_BUF, 8'h00);
        rchk("buffer written", sccsi_pkg::ADDR_STATUS, 8'h10);
        chk("buffer strobe", {7'h00, buf_seen}, 8'h01);
      end
      pulse(ev_tab[i]);
      idle(2);
      rchk("event flags", sccsi_pkg::ADDR_IRQ_FLAGS, flag_tab[i]);
      rchk("event status", sccsi_pkg::ADDR_STATUS, stat_tab[i]);
      chk("irq raised", {7'h00, irq}, 8'h01);
      wr_reg(sccsi_pkg::ADDR_IRQ_FLAGS, 8'h00);
      wr_reg(sccsi_pkg::ADDR_STATUS, 8'h00);
      idle(2);
      chk("irq released", {7'h00, irq}, 8'h00);
      rchk("status cleared", sccsi_pkg::ADDR_STATUS, 8'h90);
    end
    pulse(6'h10);
    idle(2);
    rchk("timeout flag", sccsi_pkg::ADDR_IRQ_FLAGS, 8'h08);
    wr_reg(sccsi_pkg::ADDR_STATUS, 8'h00);
    rchk("timeout kept", sccsi_pkg::ADDR_STATUS, 8'h98);
    pulse(6'h20);
    idle(2);
    rchk("timeout reload", sccsi_pkg::ADDR_STATUS, 8'h90);
    wr_reg(sccsi_pkg::ADDR_IRQ_FLAGS, 8'h00);
    wr_reg(sccsi_pkg::ADDR_IRQ_ENABLE, 8'h00);
    pulse(6'h01);
    idle(2);
    chk("irq masked", {7'h00, irq}, 8'h00);
    rchk("masked flag", sccsi_pkg::ADDR_IRQ_FLAGS, 8'h80);
    wr_reg(sccsi_pkg::ADDR_IRQ_FLAGS, 8'h00);
    wr_reg(sccsi_pkg::ADDR_IRQ_ENABLE, 8'hDF);
    $display("test events done");
    inserted <= 1'b1;
    idle(5);
    rchk("presence flag", sccsi_pkg::ADDR_IRQ_FLAGS, 8'h40);
    rchk("presence status", sccsi_pkg::ADDR_STATUS, 8'hD0);
    chk("presence irq", {7'h00, irq}, 8'h01);
    wr_reg(sccsi_pkg::ADDR_IRQ_FLAGS, 8'h00);
    supply_ok <= 1'b0;
    idle(5);
    rchk("supply flag", sccsi_pkg::ADDR_IRQ_FLAGS, 8'h10);
    rchk("supply status", sccsi_pkg::ADDR_STATUS, 8'hC0);
    $display("test presence and supply done");
    wrap_up();
  end
endmodule
